// ### verilog/slsem_map.vh
// Purpose: Constants for the serial link status and error monitor
// Assumes: Included by slsem_top.v and by the bench top module
// Notes: Counts are in sys_clk_in cycles
`ifndef SLSEM_MAP_VH
`define SLSEM_MAP_VH
// Lane count and stream width
`define SLSEM_LANES 2
`define SLSEM_DW 32
// Register byte offsets
`define SLSEM_CTRL_OFS 4'h0
`define SLSEM_STAT_OFS 4'h4
`define SLSEM_IRQ_STAT_OFS 4'h8
`define SLSEM_IRQ_EN_OFS 4'hc
`define SLSEM_IRQ_CLR_OFS 4'h0
`define SLSEM_ADDR_W 5
`define SLSEM_IRQ_CLR_ADDR 5'h10
// Control fields
`define SLSEM_CTRL_LOOP_LSB 0
`define SLSEM_CTRL_RESTART_BIT 2
`define SLSEM_LOOP_RESET 2'h0
// Interrupt status bits
`define SLSEM_IRQ_SOFT 0
`define SLSEM_IRQ_HARD 1
`define SLSEM_IRQ_UP 2
`define SLSEM_IRQ_DOWN 3
`define SLSEM_IRQ_W 4
// Elastic buffer state codes per lane (3 bits)
`define SLSEM_EBUF_UNDER 3'h5
`define SLSEM_EBUF_OVER 3'h6
// Training and verification counts
`define SLSEM_ALIGN_WAIT 16'h0040
`define SLSEM_VERIFY_NEEDED 3'h4
// Leaky bucket: level added per correctable fault, leak period, trip level
`define SLSEM_BUCKET_INC 8'h04
`define SLSEM_BUCKET_TRIP 8'h0f
`define SLSEM_LEAK_PERIOD 16'h0100
`define SLSEM_SOFT_MON_EN 1
// AXI responses
`define SLSEM_RESP_OKAY 2'h0
`define SLSEM_RESP_SLVERR 2'h2
`endif

// ### verilog/slsem_top.v
// Purpose: Status and error monitor of a multi-lane serial link layer
// Assumes: One clock sys_clk_in; transceiver status arrives asynchronously
// Notes: Registers over AXI4-Lite; lane count fixed in the map header
//
// How it works
// - Any disparity fault or invalid code group on any lane raises the correctable fault.
// - A lane is ready only after partner alignment has held for the alignment wait count.
// - The channel is ready only once all lanes are ready and four verify sequences came in.
// - Transmit data is accepted only while the channel is ready.
// - An elastic buffer overflow or underflow raises the fatal fault.
// - A leaky bucket of correctable faults that trips raises the fatal fault and restarts.
// - With the monitor parameter at zero correctable faults never escalate.
// - Alignment wait count is a parameter that can be raised for late transmitter reset.
// - A two-bit loopback control selects one of four transceiver loopback setups.
// - Transmit ready is low while sending is impossible; a word moves on ready and valid.
// - Receive valid is high only while received data is being presented.
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`include "slsem_map.vh"
`default_nettype none
module slsem_top #(
  parameter [15:0] ALIGN_WAIT = `SLSEM_ALIGN_WAIT,
  parameter SOFT_MON_EN = `SLSEM_SOFT_MON_EN
) (
  input wire sys_clk_in,
  input wire reset_in,
  input wire transceiver_reset_in,
  input wire [`SLSEM_LANES-1:0] rx_disparity_fault_in,
  input wire [`SLSEM_LANES-1:0] rx_invalid_code_group_in,
  input wire [3*`SLSEM_LANES-1:0] elastic_buffer_state_in,
  input wire [`SLSEM_LANES-1:0] lane_aligned_in,
  input wire verify_seq_in,
  input wire s_axis_tx_tvalid_in,
  input wire [`SLSEM_DW-1:0] s_axis_tx_tdata_in,
  output wire s_axis_tx_tready_out,
  output wire tx_link_valid_out,
  output wire [`SLSEM_DW-1:0] tx_link_data_out,
  input wire rx_link_valid_in,
  input wire [`SLSEM_DW-1:0] rx_link_data_in,
  output wire m_axis_rx_tvalid_out,
  output wire [`SLSEM_DW-1:0] m_axis_rx_tdata_out,
  output wire [`SLSEM_LANES-1:0] lane_ready_out,
  output wire channel_ready_out,
  output wire soft_fault_out,
  output wire hard_fault_out,
  output wire [1:0] loopback_mode_out,
  output wire irq_out,
  input wire [`SLSEM_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`SLSEM_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);
  localparam L = `SLSEM_LANES;
  localparam SW = 6 * L + 2;
  localparam CH_IDLE = 2'd0;
  localparam CH_VERIFY = 2'd1;
  localparam CH_UP = 2'd2;
  localparam LN_RESET = 2'd0;
  localparam LN_ALIGN = 2'd1;
  localparam LN_READY = 2'd2;

  // Two-stage synchroniser for every transceiver-side input
  reg [SW-1:0] meta_r;
  reg [SW-1:0] sync_r;
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      meta_r <= {SW{1'b0}};
      sync_r <= {SW{1'b0}};
    end else begin
      meta_r <= {transceiver_reset_in, verify_seq_in, lane_aligned_in,
                 elastic_buffer_state_in, rx_invalid_code_group_in, rx_disparity_fault_in};
      sync_r <= meta_r;
    end
  end
  wire [L-1:0] disp_s = sync_r[L-1:0];
  wire [L-1:0] inval_s = sync_r[2*L-1:L];
  wire [3*L-1:0] ebuf_s = sync_r[5*L-1:2*L];
  wire [L-1:0] align_s = sync_r[6*L-1:5*L];
  wire verify_s = sync_r[6*L];
  wire xcvr_rst_s = sync_r[6*L+1];

  // Fault sources; edge detect reads only the second stage
  reg verify_d_r;
  wire [L-1:0] ebuf_bad;
  wire verify_pulse = verify_s & ~verify_d_r;
  wire soft_evt = |(disp_s | inval_s);
  genvar g;
  generate
    for (g = 0; g < L; g = g + 1) begin : g_ebuf
      assign ebuf_bad[g] = (ebuf_s[3*g+2:3*g] == `SLSEM_EBUF_OVER) ||
                           (ebuf_s[3*g+2:3*g] == `SLSEM_EBUF_UNDER);
    end
  endgenerate

  // Leaky bucket: each faulty cycle adds, a slow tick leaks one unit
  reg [7:0] bucket_r;
  reg [15:0] leak_cnt_r;
  reg [7:0] bucket_nxt;
  wire leak_tick = (leak_cnt_r == `SLSEM_LEAK_PERIOD - 16'h0001);
  wire bucket_trip = (SOFT_MON_EN != 0) && (bucket_nxt >= `SLSEM_BUCKET_TRIP);
  wire hard_evt = (|ebuf_bad) | bucket_trip;
  reg restart_req_r;
  // Any fatal cause restarts the whole training sequence
  wire restart = hard_evt | xcvr_rst_s | restart_req_r;
  always @* begin
    bucket_nxt = bucket_r;
    if (soft_evt) begin
      bucket_nxt = (bucket_r > 8'hff - `SLSEM_BUCKET_INC) ? 8'hff : bucket_r + `SLSEM_BUCKET_INC;
    end else if (leak_tick && bucket_r != 8'h00) begin
      bucket_nxt = bucket_r - 8'h01;
    end
  end
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      bucket_r <= 8'h00;
      leak_cnt_r <= 16'h0000;
      verify_d_r <= 1'b0;
    end else begin
      // Emptied on a trip so one burst yields one fatal fault, not a stream
      bucket_r <= bucket_trip ? 8'h00 : bucket_nxt;
      leak_cnt_r <= leak_tick ? 16'h0000 : leak_cnt_r + 16'h0001;
      verify_d_r <= verify_s;
    end
  end

  // Per-lane training: alignment must hold unbroken for the wait count
  wire [L-1:0] lane_rdy;
  // Lane losing alignment now; lets the channel fall on the same edge as the lane
  wire [L-1:0] lane_drop;
  generate
    for (g = 0; g < L; g = g + 1) begin : g_lane
      reg [1:0] lane_st_r;
      reg [15:0] align_cnt_r;
      reg rdy_r;
      assign lane_rdy[g] = rdy_r;
      assign lane_drop[g] = (lane_st_r == LN_READY) && !align_s[g];
      always @(posedge sys_clk_in) begin
        if (reset_in || restart) begin
          lane_st_r <= LN_RESET;
          align_cnt_r <= 16'h0000;
          rdy_r <= 1'b0;
        end else begin
          case (lane_st_r)
            LN_RESET: begin
              lane_st_r <= LN_ALIGN;
              align_cnt_r <= 16'h0000;
            end
            LN_ALIGN: begin
              if (!align_s[g]) begin
                align_cnt_r <= 16'h0000;
              end else if (align_cnt_r >= ALIGN_WAIT - 16'h0001) begin
                lane_st_r <= LN_READY;
                rdy_r <= 1'b1;
              end else begin
                align_cnt_r <= align_cnt_r + 16'h0001;
              end
            end
            LN_READY: begin
              if (!align_s[g]) begin
                lane_st_r <= LN_ALIGN;
                align_cnt_r <= 16'h0000;
                rdy_r <= 1'b0;
              end
            end
            default: begin
              lane_st_r <= LN_RESET;
              rdy_r <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  // Channel verification: all lanes ready, then count verify sequences
  reg [1:0] ch_st_r;
  reg [1:0] ch_nxt;
  reg [2:0] ver_cnt_r;
  reg [2:0] ver_nxt;
  always @* begin
    ch_nxt = ch_st_r;
    ver_nxt = ver_cnt_r;
    if (restart || !(&lane_rdy) || (|lane_drop)) begin
      ch_nxt = CH_IDLE;
      ver_nxt = 3'h0;
    end else begin
      case (ch_st_r)
        CH_IDLE: begin
          ch_nxt = CH_VERIFY;
          ver_nxt = 3'h0;
        end
        CH_VERIFY: begin
          if (verify_pulse) begin
            ver_nxt = ver_cnt_r + 3'h1;
            if (ver_cnt_r + 3'h1 == `SLSEM_VERIFY_NEEDED) begin
              ch_nxt = CH_UP;
            end
          end
        end
        CH_UP: ch_nxt = CH_UP;
        default: ch_nxt = CH_IDLE;
      endcase
    end
  end
  wire ch_up = (ch_st_r == CH_UP);
  wire ch_up_nxt = (ch_nxt == CH_UP);

  // Stream paths and status outputs, all registered
  reg tready_r;
  reg tx_valid_r;
  reg [`SLSEM_DW-1:0] tx_data_r;
  reg rx_valid_r;
  reg [`SLSEM_DW-1:0] rx_data_r;
  reg soft_r;
  reg hard_r;
  reg [1:0] loop_r;
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      ch_st_r <= CH_IDLE;
      ver_cnt_r <= 3'h0;
      tready_r <= 1'b0;
      tx_valid_r <= 1'b0;
      tx_data_r <= {`SLSEM_DW{1'b0}};
      rx_valid_r <= 1'b0;
      rx_data_r <= {`SLSEM_DW{1'b0}};
      soft_r <= 1'b0;
      hard_r <= 1'b0;
    end else begin
      ch_st_r <= ch_nxt;
      ver_cnt_r <= ver_nxt;
      tready_r <= ch_up_nxt;
      tx_valid_r <= s_axis_tx_tvalid_in & tready_r;
      if (s_axis_tx_tvalid_in && tready_r) begin
        tx_data_r <= s_axis_tx_tdata_in;
      end
      rx_valid_r <= rx_link_valid_in & ch_up;
      if (rx_link_valid_in) begin
        rx_data_r <= rx_link_data_in;
      end
      soft_r <= soft_evt;
      hard_r <= hard_evt;
    end
  end

  // AXI4-Lite slave: address and data latched in either order
  reg awr_r;
  reg wr_r;
  reg [`SLSEM_ADDR_W-1:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg arready_r;
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;
  reg [`SLSEM_IRQ_W-1:0] irq_stat_r;
  reg [`SLSEM_IRQ_W-1:0] irq_en_r;
  reg irq_r;
  reg ch_up_d_r;
  wire do_wr = awr_r && wr_r && !bvalid_r;
  wire [`SLSEM_IRQ_W-1:0] irq_clr =
    (do_wr && awaddr_r == `SLSEM_IRQ_CLR_ADDR) ? wdata_r[`SLSEM_IRQ_W-1:0] : 4'h0;
  wire [`SLSEM_IRQ_W-1:0] irq_set = {ch_up_d_r & ~ch_up, ch_up & ~ch_up_d_r, hard_evt, soft_evt};
  wire wr_hit = (awaddr_r == {1'b0, `SLSEM_CTRL_OFS}) ||
                (awaddr_r == {1'b0, `SLSEM_IRQ_EN_OFS}) || (awaddr_r == `SLSEM_IRQ_CLR_ADDR);
  reg [31:0] rd_mux;
  reg rd_ok;
  // Read decode; unmapped addresses return zero with a slave error
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      {1'b0, `SLSEM_CTRL_OFS}: rd_mux = {30'h0, loop_r};
      {1'b0, `SLSEM_STAT_OFS}: rd_mux = {16'h0, bucket_r, 5'h0, ch_up, lane_rdy};
      {1'b0, `SLSEM_IRQ_STAT_OFS}: rd_mux = {28'h0, irq_stat_r};
      {1'b0, `SLSEM_IRQ_EN_OFS}: rd_mux = {28'h0, irq_en_r};
      `SLSEM_IRQ_CLR_ADDR: rd_mux = 32'h0000_0000;
      default: rd_ok = 1'b0;
    endcase
  end
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      awr_r <= 1'b0;
      wr_r <= 1'b0;
      awaddr_r <= {`SLSEM_ADDR_W{1'b0}};
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `SLSEM_RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `SLSEM_RESP_OKAY;
      loop_r <= `SLSEM_LOOP_RESET;
      restart_req_r <= 1'b0;
      irq_stat_r <= {`SLSEM_IRQ_W{1'b0}};
      irq_en_r <= {`SLSEM_IRQ_W{1'b0}};
      irq_r <= 1'b0;
      ch_up_d_r <= 1'b0;
    end else begin
      ch_up_d_r <= ch_up;
      restart_req_r <= 1'b0;
      if (s_axi_awvalid && !awr_r && !bvalid_r) begin
        awr_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wr_r && !bvalid_r) begin
        wr_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        awr_r <= 1'b0;
        wr_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `SLSEM_RESP_OKAY : `SLSEM_RESP_SLVERR;
        if (awaddr_r == {1'b0, `SLSEM_CTRL_OFS}) begin
          if (wstrb_r[0]) begin
            loop_r <= wdata_r[`SLSEM_CTRL_LOOP_LSB+1:`SLSEM_CTRL_LOOP_LSB];
            restart_req_r <= wdata_r[`SLSEM_CTRL_RESTART_BIT];
          end
        end
        if (awaddr_r == {1'b0, `SLSEM_IRQ_EN_OFS} && wstrb_r[0]) begin
          irq_en_r <= wdata_r[`SLSEM_IRQ_W-1:0];
        end
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      // One read in flight: ready for one cycle, answer the cycle after
      arready_r <= s_axi_arvalid && !arready_r && !rvalid_r;
      if (s_axi_arvalid && !arready_r && !rvalid_r) begin
        rdata_r <= rd_mux;
        rresp_r <= rd_ok ? `SLSEM_RESP_OKAY : `SLSEM_RESP_SLVERR;
      end
      if (arready_r) begin
        rvalid_r <= 1'b1;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
      // Sticky status: a new event outranks a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      irq_r <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
    end
  end

  assign s_axis_tx_tready_out = tready_r;
  assign tx_link_valid_out = tx_valid_r;
  assign tx_link_data_out = tx_data_r;
  assign m_axis_rx_tvalid_out = rx_valid_r;
  assign m_axis_rx_tdata_out = rx_data_r;
  assign lane_ready_out = lane_rdy;
  assign channel_ready_out = ch_st_r == CH_UP ? 1'b1 : 1'b0;
  assign soft_fault_out = soft_r;
  assign hard_fault_out = hard_r;
  assign loopback_mode_out = loop_r;
  assign irq_out = irq_r;
  assign s_axi_awready = awr_r ? 1'b0 : !bvalid_r;
  assign s_axi_wready = wr_r ? 1'b0 : !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule
`default_nettype wire

// ### testbench/slsem_chk.sv
// Purpose: Port-level checks of the link status and error monitor
// Assumes: One clock, synchronous active-high reset
// Notes: Input latencies allow for two synchroniser stages
`default_nettype none
module slsem_chk (
  input wire sys_clk_in,
  input wire reset_in,
  input wire [1:0] rx_disparity_fault_in,
  input wire [1:0] rx_invalid_code_group_in,
  input wire [5:0] elastic_buffer_state_in,
  input wire [1:0] lane_aligned_in,
  input wire s_axis_tx_tvalid_in,
  input wire [31:0] s_axis_tx_tdata_in,
  input wire s_axis_tx_tready_out,
  input wire tx_link_valid_out,
  input wire [31:0] tx_link_data_out,
  input wire rx_link_valid_in,
  input wire [31:0] rx_link_data_in,
  input wire m_axis_rx_tvalid_out,
  input wire [31:0] m_axis_rx_tdata_out,
  input wire [1:0] lane_ready_out,
  input wire channel_ready_out,
  input wire soft_fault_out,
  input wire hard_fault_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Underflow and overflow codes of either lane
  wire [2:0] e0 = elastic_buffer_state_in[2:0];
  wire [2:0] e1 = elastic_buffer_state_in[5:3];
  wire ebuf_bad = e0 == 3'h5 || e0 == 3'h6 || e1 == 3'h5 || e1 == 3'h6;
  wire code_bad = |rx_disparity_fault_in || |rx_invalid_code_group_in;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  property p_tready; s_axis_tx_tready_out |-> channel_ready_out; endproperty
  a_tready: assert property (p_tready) else $error("tready without channel");
  property p_txfwd;
    s_axis_tx_tvalid_in && s_axis_tx_tready_out |=>
      tx_link_valid_out && tx_link_data_out == $past(s_axis_tx_tdata_in);
  endproperty
  a_txfwd: assert property (p_txfwd) else $error("accepted word not sent");
  property p_txonly;
    tx_link_valid_out |-> $past(s_axis_tx_tvalid_in && s_axis_tx_tready_out);
  endproperty
  a_txonly: assert property (p_txonly) else $error("word sent unaccepted");
  property p_rx;
    m_axis_rx_tvalid_out |-> $past(rx_link_valid_in) &&
      m_axis_rx_tdata_out == $past(rx_link_data_in);
  endproperty
  a_rx: assert property (p_rx) else $error("rx valid without data");
  property p_soft; code_bad |-> ##[1:5] soft_fault_out; endproperty
  a_soft: assert property (p_soft) else $error("code fault missed");
  property p_ebuf; ebuf_bad |-> ##[1:5] hard_fault_out; endproperty
  a_ebuf: assert property (p_ebuf) else $error("buffer fault missed");
  property p_drop; hard_fault_out |=> !channel_ready_out && lane_ready_out == 2'h0; endproperty
  a_drop: assert property (p_drop) else $error("ready kept after fatal");
  property p_chan; channel_ready_out |-> lane_ready_out == 2'h3; endproperty
  a_chan: assert property (p_chan) else $error("channel up without lanes");
  property p_lane; (!lane_aligned_in[0]) [*5] |-> !lane_ready_out[0]; endproperty
  a_lane: assert property (p_lane) else $error("lane ready unaligned");
endmodule
bind slsem_top slsem_chk slsem_chk_i (.*);
`default_nettype wire

// ### testbench/slsem_partner.sv
// Purpose: Behavioural far-end link partner
// Assumes: Shares the bench clock
// Notes: GAP sets how slowly verify sequences arrive
`default_nettype none
module slsem_partner #(
  parameter int GAP = 3
) (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic send_in,
  input wire logic [31:0] word_in,
  output logic verify_out,
  output logic rx_valid_out,
  output logic [31:0] rx_data_out,
  output int sent_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial begin
    verify_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_data_out = 32'h0;
    sent_out = 0;
  end
  // Verify sequences only while training is requested
  always @(posedge clk_in) begin
    cnt <= (go_in && cnt < 2 * GAP - 1) ? cnt + 1 : 0;
    verify_out <= go_in && cnt >= GAP - 1 && cnt < 2 * GAP - 1;
    if (go_in && cnt == GAP - 1) sent_out <= sent_out + 1;
  end
  // Idle data is inverted so a stale word never looks fresh
  always @(posedge clk_in) begin
    rx_valid_out <= send_in;
    rx_data_out <= send_in ? word_in : ~rx_data_out;
  end
endmodule
`default_nettype wire

// ### testbench/slsem_tb_top.sv
// Purpose: Self-checking bench for the link status and error monitor
// Assumes: Alignment wait shortened to 4 cycles
// Notes: Queues model both stream paths
`include "slsem_map.vh"
`default_nettype none
module slsem_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in = 0, reset_in = 1, transceiver_reset_in = 0, verify_seq_in;
  logic s_axis_tx_tvalid_in = 0, s_axis_tx_tready_out, tx_link_valid_out, rx_link_valid_in;
  logic m_axis_rx_tvalid_out, channel_ready_out, soft_fault_out, hard_fault_out, irq_out;
  logic s_axi_awvalid = 0, s_axi_awready, s_axi_wvalid = 0, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready = 1, s_axi_arvalid = 0, s_axi_arready, s_axi_rvalid, s_axi_rready = 1;
  logic [1:0] rx_disparity_fault_in = 0, rx_invalid_code_group_in = 0, lane_aligned_in = 0;
  logic [1:0] lane_ready_out, loopback_mode_out, s_axi_bresp, s_axi_rresp, resp;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [5:0] elastic_buffer_state_in = 0;
  logic [31:0] s_axis_tx_tdata_in = 0, tx_link_data_out, rx_link_data_in, m_axis_rx_tdata_out;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, word = 0, seed = 32'h00012e76;
  logic [31:0] txq[$], rxq[$];
  logic go = 0, rx_on = 0, send = 0;
  int n_mismatch = 0, checks_done = 0, n_soft = 0, n_hard = 0, sent;
  slsem_top #(.ALIGN_WAIT(16'h0004)) slsem_top_i (.*);
  slsem_partner #(.GAP(3)) slsem_partner_i (.clk_in(sys_clk_in), .go_in(go), .send_in(send),
    .word_in(word), .verify_out(verify_seq_in), .rx_valid_out(rx_link_valid_in),
    .rx_data_out(rx_link_data_in), .sent_out(sent));
  always #5 sys_clk_in = ~sys_clk_in;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Register write: both halves offered together, each released when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (aw || w) begin
      @(posedge sys_clk_in);
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge sys_clk_in); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask
  task automatic rdr(input logic [4:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge sys_clk_in); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge sys_clk_in); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  // Verify sequences until the channel comes up, bounded
  task automatic train();
    go <= 1;
    for (int i = 0; i < 500 && channel_ready_out !== 1'b1; i++) @(posedge sys_clk_in);
    go <= 0;
    chk(channel_ready_out === 1'b1 && lane_ready_out === 2'h3, "channel up");
  endtask
  // Scoreboard, fault counters and random stream stimulus
  always @(posedge sys_clk_in) begin
    if (tx_link_valid_out)
      chk(txq.size() > 0 && tx_link_data_out === txq.pop_front(), "tx");
    if (m_axis_rx_tvalid_out)
      chk(rxq.size() > 0 && m_axis_rx_tdata_out === rxq.pop_front(), "rx");
    if (s_axis_tx_tvalid_in && s_axis_tx_tready_out) txq.push_back(s_axis_tx_tdata_in);
    if (rx_link_valid_in && channel_ready_out) rxq.push_back(rx_link_data_in);
    n_soft += (soft_fault_out === 1'b1);
    n_hard += (hard_fault_out === 1'b1);
    if (!s_axis_tx_tvalid_in || s_axis_tx_tready_out) begin
      s_axis_tx_tvalid_in <= seed[3];
      s_axis_tx_tdata_in <= xs();
    end
    send <= rx_on & seed[7];
    word <= seed;
  end
  initial begin
    repeat (30000) @(posedge sys_clk_in);
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge sys_clk_in);
    reset_in <= 0;
    @(posedge sys_clk_in);
    chk(s_axis_tx_tready_out === 1'b0 && channel_ready_out === 1'b0, "ready at reset");
    for (int m = 0; m < 4; m++) begin
      wr(5'h00, 32'(m));
      rdr(5'h00);
      chk(loopback_mode_out === m[1:0] && rd[1:0] === m[1:0], "loopback");
    end
    rdr(5'h14);
    chk(resp === `SLSEM_RESP_SLVERR && rd === 32'h0, "unmapped read");
    wr(5'h0c, 32'h1 << `SLSEM_IRQ_HARD);
    lane_aligned_in <= 2'h3;
    repeat (4) @(posedge sys_clk_in);
    chk(lane_ready_out === 2'h0, "lane early");
    for (int i = 0; i < 100 && lane_ready_out !== 2'h3; i++) @(posedge sys_clk_in);
    chk(lane_ready_out === 2'h3, "lanes up");
    go <= 1;
    for (int i = 0; i < 100 && sent < `SLSEM_VERIFY_NEEDED - 1; i++) @(posedge sys_clk_in);
    go <= 0;
    repeat (20) @(posedge sys_clk_in);
    chk(channel_ready_out === 1'b0, "three verifies");
    train();
    rx_on <= 1;
    repeat (200) @(posedge sys_clk_in);
    rx_on <= 0;
    repeat (4) @(posedge sys_clk_in);
    chk(rxq.size() == 0, "rx drained");
    n_soft = 0;
    n_hard = 0;
    for (int i = 0; i < 3; i++) begin
      rx_disparity_fault_in[i[0]] <= 1'b1;
      @(posedge sys_clk_in);
      rx_disparity_fault_in <= 2'h0;
      repeat (8) @(posedge sys_clk_in);
    end
    chk(n_soft == 3 && n_hard == 0, "three soft faults");
    rdr(5'h04);
    chk(rd[15:8] >= 3 * `SLSEM_BUCKET_INC - 1 &&
        rd[15:8] <= 3 * `SLSEM_BUCKET_INC, "bucket");
    rx_invalid_code_group_in <= 2'h2;
    @(posedge sys_clk_in);
    rx_invalid_code_group_in <= 2'h0;
    repeat (8) @(posedge sys_clk_in);
    chk(n_soft == 4 && n_hard > 0 && channel_ready_out === 1'b0, "burst trips");
    chk(irq_out === 1'b1, "irq raised");
    wr(5'h0c, 32'h0);
    repeat (2) @(posedge sys_clk_in);
    chk(irq_out === 1'b0, "irq masked");
    wr(`SLSEM_IRQ_CLR_ADDR, 32'h1 << `SLSEM_IRQ_HARD);
    rdr(5'h08);
    chk(rd[`SLSEM_IRQ_HARD] === 1'b0, "irq cleared");
    train();
    for (int i = 0; i < 2; i++) begin
      n_hard = 0;
      elastic_buffer_state_in <= i ? {`SLSEM_EBUF_OVER, 3'h0} : {3'h0, `SLSEM_EBUF_UNDER};
      @(posedge sys_clk_in);
      elastic_buffer_state_in <= 6'h00;
      repeat (8) @(posedge sys_clk_in);
      chk(n_hard > 0 && channel_ready_out === 1'b0, "buffer fault");
      train();
    end
    // Transceiver reset restarts training without a fatal fault
    n_hard = 0;
    transceiver_reset_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    transceiver_reset_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    chk(n_hard == 0 && channel_ready_out === 1'b0 && lane_ready_out === 0, "xcvr reset");
    train();
    // Restart bit drops the channel, also without a fatal fault
    wr(5'h00, 32'h1 << `SLSEM_CTRL_RESTART_BIT);
    @(posedge sys_clk_in);
    chk(n_hard == 0 && channel_ready_out === 1'b0, "restart bit");
    train();
    // Lane 0 loses alignment: its flag and the channel fall together
    lane_aligned_in <= 2'h2;
    repeat (6) @(posedge sys_clk_in);
    chk(lane_ready_out === 2'h2 && channel_ready_out === 1'b0, "lane lost");
    test_done();
  end
endmodule
`default_nettype wire
